/* test/wdg_watchdog_chk.sv */
// Port checker for the watchdog block.
`include "wdg_cfg.svh"
module wdg_watchdog_chk #(
   parameter int RC_DIV = `WDG_RC_DIV
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        porRst,
   input wire logic        sfrWr,
   input wire logic        sfrRd,
   input wire logic [7:0]  sfrAddr,
   input wire logic [7:0]  sfrWdata,
   input wire logic [7:0]  sfrRdata,
   input wire logic        chipRstReq,
   input wire logic        irqReq,
   input wire logic        wakeReq,
   input wire logic [15:0] irqVector
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int MinGap = 255 * RC_DIV;
   logic [1:0]  keyFf;
   logic [3:0]  divFf, irqDivFf;
   logic        enFf, irqEnFf, ie2Ff, wrR, wrI;
   logic [19:0] gapFf;
   assign wrR = sfrWr && keyFf == 2'h3 && sfrAddr == `WDG_ADDR_RSTCTL;
   assign wrI = sfrWr && keyFf == 2'h3 && sfrAddr == `WDG_ADDR_IRQCTL;
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         keyFf <= 2'h0;
      else if (chipRstReq)
         keyFf <= 2'h0;
      else if (sfrWr && sfrAddr == `WDG_ADDR_TIMED_ACCESS_KEY)
         keyFf <= (keyFf == 2'h1 && sfrWdata == `WDG_KEY_UNLOCK_2) ? 2'h2 :
            (keyFf == 2'h2 && sfrWdata == `WDG_KEY_UNLOCK_3) ? 2'h3 :
            ((keyFf == 2'h0 || keyFf == 2'h3) &&
             sfrWdata == `WDG_KEY_UNLOCK_1) ? 2'h1 : 2'h0;
      else if (wrR || wrI)
         keyFf <= 2'h0;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enFf <= 1'h0;
         divFf <= 4'h4;
         irqEnFf <= 1'h0;
         irqDivFf <= 4'h0;
         ie2Ff <= 1'h0;
      end else begin
         if (chipRstReq) begin
            enFf <= 1'h0;
            divFf <= 4'h4;
            irqEnFf <= 1'h0;
            irqDivFf <= 4'h0;
         end else begin
            if (wrR) begin
               enFf <= enFf | sfrWdata[5];
               divFf <= sfrWdata[3:0];
            end
            if (wrI) begin
               irqEnFf <= sfrWdata[5];
               irqDivFf <= sfrWdata[3:0];
            end
         end
         if (sfrWr && sfrAddr == `WDG_ADDR_IRQEN2)
            ie2Ff <= sfrWdata[1];
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         gapFf <= 20'hFFFFF;
      else if (sfrWr && sfrAddr == `WDG_ADDR_REFRESH &&
               (sfrWdata == 8'h55 || sfrWdata == 8'hAA))
         gapFf <= 20'h00000;
      else if (gapFf != 20'hFFFFF)
         gapFf <= gapFf + 20'h00001;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_rdRst; sfrRd && sfrAddr == `WDG_ADDR_RSTCTL; endsequence
   sequence s_rdIrq; sfrRd && sfrAddr == `WDG_ADDR_IRQCTL; endsequence
   property p_vector; irqVector == `WDG_IRQ_VECTOR; endproperty
   property p_rstPulse; chipRstReq |=> !chipRstReq; endproperty
   property p_wakePulse; wakeReq |=> !wakeReq; endproperty
   property p_rstGate; chipRstReq |-> enFf; endproperty
   property p_irqGate; irqReq |-> $past(ie2Ff); endproperty
   property p_gap; chipRstReq |-> gapFf >= MinGap; endproperty
   property p_rdRst;
      s_rdRst |=> sfrRdata[5] == $past(enFf) && sfrRdata[3:0] == $past(divFf);
   endproperty
   property p_rdIrq;
      s_rdIrq |=> sfrRdata[5] == $past(irqEnFf) &&
         sfrRdata[3:0] == $past(irqDivFf);
   endproperty
   a_vector: assert property (p_vector)
      else $error("Vector wrong.");
   a_rstPulse: assert property (p_rstPulse)
      else $error("Reset request too long.");
   a_wakePulse: assert property (p_wakePulse)
      else $error("Wake request too long.");
   a_rstGate: assert property (p_rstGate)
      else $error("Reset request while disabled.");
   a_irqGate: assert property (p_irqGate)
      else $error("Interrupt while masked.");
   a_gap: assert property (p_gap)
      else $error("Reset request too soon after refresh.");
   a_rdRst: assert property (p_rdRst)
      else $error("Reset control readback wrong.");
   a_rdIrq: assert property (p_rdIrq)
      else $error("Interrupt control readback wrong.");
endmodule : wdg_watchdog_chk
bind wdg_watchdog wdg_watchdog_chk #(.RC_DIV(RC_DIV)) uChk (.clk(clk), .rst(rst),
   .porRst(porRst), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrAddr(sfrAddr),
   .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .chipRstReq(chipRstReq),
   .irqReq(irqReq), .wakeReq(wakeReq), .irqVector(irqVector));

/* test/wdg_watchdog_tb.sv */
// Self-checking bench for the watchdog block.
`include "wdg_cfg.svh"
module wdg_watchdog_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic       ul;
      logic [7:0] addr;
      logic [7:0] data;
      logic [7:0] mask;
      logic [7:0] exp;
   } wdg_row_t;
   logic        clk, rst, porRst, sfrWr, sfrRd, chipRstReq, irqReq, wakeReq;
   logic [7:0]  sfrAddr, sfrWdata, sfrRdata;
   logic [15:0] irqVector;
   int          n_mismatch, comparisons, n;
   localparam int RcDiv = 4;
   localparam int EvLo  = 255 * RcDiv + 2;
   localparam int EvHi  = 256 * RcDiv + 1;
   wdg_row_t    rows [7];
   wdg_watchdog #(.RC_DIV(RcDiv)) uut (.clk(clk), .rst(rst),
      .porRst(porRst), .sfrWr(sfrWr),
      .sfrRd(sfrRd), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
      .sfrRdata(sfrRdata), .chipRstReq(chipRstReq), .irqReq(irqReq),
      .wakeReq(wakeReq), .irqVector(irqVector));
   always #25 clk = ~clk;
   task complete_run;
      if (n_mismatch == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfrWr = 1'h1;
      sfrAddr = a;
      sfrWdata = d;
      @(negedge clk);
      sfrWr = 1'h0;
   endtask : wr
   task rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(negedge clk);
      sfrRd = 1'h1;
      sfrAddr = a;
      @(negedge clk);
      sfrRd = 1'h0;
      @(negedge clk);
      chk({8'h00, sfrRdata & m}, {8'h00, e});
   endtask : rc
   // Counts cycles to an overflow event; a bad refresh key is written midway.
   task waitEv(input logic sel);
      n = 0;
      sfrAddr = `WDG_ADDR_REFRESH;
      sfrWdata = 8'h12;
      do begin
         @(negedge clk);
         n++;
         sfrWr = (n == EvLo / 2);
      end while (!(sel ? chipRstReq : wakeReq) && n < 2 * EvHi);
   endtask : waitEv
   task unlock;
      wr(`WDG_ADDR_TIMED_ACCESS_KEY, 8'h55);
      wr(`WDG_ADDR_TIMED_ACCESS_KEY, 8'hAA);
      wr(`WDG_ADDR_TIMED_ACCESS_KEY, 8'h5A);
   endtask : unlock
   task resetChecks;
      rc(`WDG_ADDR_RSTCTL, 8'h2F, 8'h04);
      rc(`WDG_ADDR_IRQCTL, 8'h3F, 8'h00);
      rc(`WDG_ADDR_IRQEN2, 8'h02, 8'h00);
      rc(`WDG_ADDR_RSTCAUSE, 8'h08, 8'h00);
   endtask : resetChecks
   initial begin
      #1000000;
      n_mismatch++;
      complete_run();
   end
   initial begin
      clk = 1'h0;
      rst = 1'h1;
      porRst = 1'h1;
      sfrWr = 1'h0;
      sfrRd = 1'h0;
      sfrAddr = 8'h00;
      sfrWdata = 8'h00;
      rows[0] = '{1'h0, `WDG_ADDR_RSTCTL, 8'h23, 8'h2F, 8'h04};
      rows[1] = '{1'h1, `WDG_ADDR_RSTCTL, 8'h21, 8'h2F, 8'h21};
      rows[2] = '{1'h1, `WDG_ADDR_RSTCTL, 8'h01, 8'h2F, 8'h21};
      rows[3] = '{1'h0, `WDG_ADDR_IRQCTL, 8'h25, 8'h2F, 8'h00};
      rows[4] = '{1'h1, `WDG_ADDR_IRQCTL, 8'h25, 8'h2F, 8'h25};
      rows[5] = '{1'h0, `WDG_ADDR_IRQCTL, 8'h03, 8'h2F, 8'h25};
      rows[6] = '{1'h0, `WDG_ADDR_IRQEN2, 8'h02, 8'h02, 8'h02};
      repeat (8) @(negedge clk);
      rst = 1'h0;
      porRst = 1'h0;
      resetChecks();
      chk(irqVector, `WDG_IRQ_VECTOR);
      foreach (rows[i]) begin
         if (rows[i].ul)
            unlock();
         wr(rows[i].addr, rows[i].data);
         rc(rows[i].addr, rows[i].mask, rows[i].exp);
      end
      wr(`WDG_ADDR_TIMED_ACCESS_KEY, 8'h55);
      wr(`WDG_ADDR_TIMED_ACCESS_KEY, 8'h11);
      wr(`WDG_ADDR_TIMED_ACCESS_KEY, 8'h5A);
      wr(`WDG_ADDR_IRQCTL, 8'h00);
      rc(`WDG_ADDR_IRQCTL, 8'h2F, 8'h25);
      wr(`WDG_ADDR_TIMED_ACCESS_KEY, 8'h55);
      wr(`WDG_ADDR_REFRESH, 8'h12);
      wr(`WDG_ADDR_TIMED_ACCESS_KEY, 8'hAA);
      wr(`WDG_ADDR_TIMED_ACCESS_KEY, 8'h5A);
      wr(`WDG_ADDR_IRQCTL, 8'h24);
      rc(`WDG_ADDR_IRQCTL, 8'h2F, 8'h24);
      wr(`WDG_ADDR_REFRESH, 8'h55);
      wr(`WDG_ADDR_REFRESH, 8'hAA);
      chk({14'h0000, chipRstReq, irqReq}, 16'h0000);
      rst = 1'h1;
      porRst = 1'h1;
      repeat (2) @(negedge clk);
      rst = 1'h0;
      porRst = 1'h0;
      resetChecks();
      wr(`WDG_ADDR_IRQEN2, 8'h02);
      unlock();
      wr(`WDG_ADDR_IRQCTL, 8'h20);
      waitEv(1'h0);
      chk({15'h0000, n >= EvLo && n <= EvHi}, 16'h0001);
      @(negedge clk);
      chk({14'h0000, wakeReq, irqReq}, 16'h0001);
      rc(`WDG_ADDR_IRQCTL, 8'h3F, 8'h30);
      unlock();
      wr(`WDG_ADDR_IRQCTL, 8'h00);
      rc(`WDG_ADDR_IRQCTL, 8'h3F, 8'h00);
      chk({14'h0000, wakeReq, irqReq}, 16'h0000);
      unlock();
      wr(`WDG_ADDR_RSTCTL, 8'h20);
      repeat (EvLo - 300) @(negedge clk);
      wr(`WDG_ADDR_REFRESH, 8'h55);
      waitEv(1'h1);
      chk({15'h0000, n >= EvLo && n <= EvHi}, 16'h0001);
      rc(`WDG_ADDR_RSTCAUSE, 8'h08, 8'h08);
      rc(`WDG_ADDR_RSTCTL, 8'h2F, 8'h04);
      rst = 1'h1;
      repeat (2) @(negedge clk);
      rst = 1'h0;
      rc(`WDG_ADDR_RSTCAUSE, 8'h08, 8'h08);
      wr(`WDG_ADDR_RSTCAUSE, 8'h00);
      rc(`WDG_ADDR_RSTCAUSE, 8'h08, 8'h00);
      complete_run();
   end
endmodule : wdg_watchdog_tb

/* verilog/wdg_cfg.svh */
// Offsets, field positions, reset values and timing constants of the watchdog.
`ifndef WDG_CFG_SVH
`define WDG_CFG_SVH
`define WDG_ADDR_RSTCAUSE   8'hA1
`define WDG_ADDR_RSTCTL     8'hB6
`define WDG_ADDR_REFRESH    8'hB7
`define WDG_ADDR_TIMED_ACCESS_KEY      8'hF7
`define WDG_ADDR_IRQCTL     8'hFF
`define WDG_ADDR_IRQEN2     8'h9A
`define WDG_RSTCTL_RESET    8'h04
`define WDG_IRQCTL_RESET    8'h00
`define WDG_BIT_ENABLE      5
`define WDG_BIT_IRQOVF      4
`define WDG_BIT_DOGCAUSE    3
`define WDG_BIT_IRQEN2      1
`define WDG_KEY_REFRESH_A   8'h55
`define WDG_KEY_REFRESH_B   8'hAA
`define WDG_KEY_UNLOCK_1    8'h55
`define WDG_KEY_UNLOCK_2    8'hAA
`define WDG_KEY_UNLOCK_3    8'h5A
`define WDG_IRQ_VECTOR      16'h008B
`define WDG_RC_KHZ          23
`define WDG_SYS_KHZ         20000
`define WDG_RC_DIV          (`WDG_SYS_KHZ / `WDG_RC_KHZ)
`endif

/* verilog/wdg_pkg.sv */
// Types shared by the watchdog modules.
package wdg_pkg;
   typedef enum logic [1:0] {
      WDG_LOCKED = 2'b00,
      WDG_GOT1   = 2'b01,
      WDG_GOT2   = 2'b10,
      WDG_OPEN   = 2'b11
   } wdg_unlock_t;
endpackage : wdg_pkg

/* verilog/wdg_tick_if.sv */
// Interface carrying the refresh event and the selected divider to a timer.
interface wdg_tick_if;
   logic       refresh;
   logic       run;
   logic [3:0] divSel;
   logic       rcTick;
   logic       overflow;
   modport ctl (output refresh, output run, output divSel, output rcTick,
                input overflow);
   modport tmr (input refresh, input run, input divSel, input rcTick,
                output overflow);
endinterface : wdg_tick_if

/* verilog/wdg_timer.sv */
// One divided 8-bit watchdog timer that pulses on overflow.
module wdg_timer #(
   parameter int PRE_W = 15
) (
   input wire logic clk,
   input wire logic rst,
   wdg_tick_if.tmr  tk
);
   if (PRE_W < 15) begin : g_badPre
      $error("wdg_timer: prescaler must hold at least 15 bits");
   end
   logic [PRE_W-1:0] pre_ff;
   logic [7:0]       cnt_ff;
   logic             ovf_ff;
   logic             divTick;
   logic [PRE_W:0]   mask;
   assign mask = ({{PRE_W{1'b0}}, 1'b1} << tk.divSel) - 1'b1;
   assign divTick = tk.rcTick && ((pre_ff & mask[PRE_W-1:0]) == mask[PRE_W-1:0]);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pre_ff <= '0;
      end else if (tk.refresh || !tk.run) begin
         pre_ff <= '0;
      end else if (tk.rcTick) begin
         pre_ff <= pre_ff + 1'b1;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= 8'h00;
         ovf_ff <= 1'b0;
      end else begin
         ovf_ff <= 1'b0;
         if (tk.refresh || !tk.run) begin
            cnt_ff <= 8'h00;
         end else if (divTick) begin
            cnt_ff <= cnt_ff + 8'h01;
            ovf_ff <= (cnt_ff == 8'hFF);
         end
      end
   end
   assign tk.overflow = ovf_ff;
endmodule : wdg_timer

/* verilog/wdg_watchdog.sv */
// Watchdog reset and interrupt timer with its special function registers.
`include "wdg_cfg.svh"
// Notes on behaviour
// R01 - Eight-bit up-counter whose overflow requests chip reset when enabled.
// R02 - Counts a roughly 23 kHz RC tick that runs during sleep.
// R03 - Reset time base is RC divided by two to the field; 256 ticks.
// R04 - Reset divider field resets to 0100, a divide-by-16 base.
// R05 - Separate interrupt timer with own divider field, 256 divided ticks.
// R06 - Writing reset enable starts the counter and overflow asserts reset.
// R07 - Reset enable clears on every chip reset, including watchdog reset.
// R08 - Software cannot stop the running reset timer; only reset does.
// R09 - Writing 55h or AAh to refresh key clears both counters.
// R10 - Overflow sets the reset-cause flag, which survives the watchdog reset.
// R11 - External reset leaves the watchdog disabled, registers at reset values.
// R12 - Control registers writable only after 55h, AAh, 5Ah key sequence.
// R13 - Interrupt timer overflow sets its flag; software clears it.
// R14 - Interrupt timer overflow raises interrupt and wakes from stop.
// R15 - Interrupt request uses its own flag, vectored to 008Bh.
// R16 - Interrupt reaches the processor only when its enable bit is set.
// R17 - Other values written to the refresh key are ignored.
// R18 - RC ticks and events cross safely; nothing lost or duplicated.
module wdg_watchdog #(
   parameter int RC_DIV = `WDG_RC_DIV
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       porRst,
   input  wire logic       sfrWr,
   input  wire logic       sfrRd,
   input  wire logic [7:0] sfrAddr,
   input  wire logic [7:0] sfrWdata,
   output logic      [7:0] sfrRdata,
   output logic            chipRstReq,
   output logic            irqReq,
   output logic            wakeReq,
   output logic     [15:0] irqVector
);
   wdg_pkg::wdg_unlock_t unlock_ff;
   wdg_pkg::wdg_unlock_t nxt_unlock;
   logic [3:0]  rstDiv_ff;
   logic        rstEn_ff;
   logic [3:0]  irqDiv_ff;
   logic        irqEn_ff;
   logic        irqOvf_ff;
   logic        dogCause_ff;
   logic        irqEnTwo_ff;
   logic        dogIrq_ff;
   logic [7:0]  rdata_ff;
   logic        chipRst_ff;
   logic        wake_ff;
   logic [15:0] rcCnt_ff;
   logic [15:0] irqVec_ff;
   logic        rcTick_ff;
   logic        refresh;
   logic        ctlOpen;
   logic        wrRstCtl;
   logic        wrIrqCtl;
   wdg_tick_if  rstTk ();
   wdg_tick_if  irqTk ();

   // The RC tick counter is 16 bits wide and needs at least two states.
   if (RC_DIV < 2 || RC_DIV > 65536) begin : g_badRcDiv
      $error("wdg_watchdog: RC_DIV must lie in 2 to 65536");
   end

   // A free RC tick near 23 kHz; it is derived here and never gated by sleep.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rcCnt_ff  <= 16'h0000;
         rcTick_ff <= 1'b0;
      end else if (rcCnt_ff == 16'(RC_DIV - 1)) begin // R02
         rcCnt_ff  <= 16'h0000;
         rcTick_ff <= 1'b1;
      end else begin
         rcCnt_ff  <= rcCnt_ff + 16'h0001;
         rcTick_ff <= 1'b0;
      end
   end

   // Refresh is one synchronous event seen by both timers in the same cycle.
   assign refresh = sfrWr && (sfrAddr == `WDG_ADDR_REFRESH)
                    && ((sfrWdata == `WDG_KEY_REFRESH_A)
                        || (sfrWdata == `WDG_KEY_REFRESH_B)); // R09 R17 R18

   assign rstTk.refresh = refresh;
   assign rstTk.run     = rstEn_ff; // R06
   assign rstTk.divSel  = rstDiv_ff; // R03
   assign rstTk.rcTick  = rcTick_ff;
   assign irqTk.refresh = refresh;
   assign irqTk.run     = irqEn_ff;
   assign irqTk.divSel  = irqDiv_ff; // R05
   assign irqTk.rcTick  = rcTick_ff;

   wdg_timer #(.PRE_W(15)) u_rstTimer (
      .clk (clk),
      .rst (rst),
      .tk  (rstTk)
   ); // R01

   wdg_timer #(.PRE_W(15)) u_irqTimer (
      .clk (clk),
      .rst (rst),
      .tk  (irqTk)
   ); // R05

   // Timed-access sequence; any other write to the key port relocks.
   always_comb begin
      nxt_unlock = unlock_ff;
      if (sfrWr && sfrAddr == `WDG_ADDR_TIMED_ACCESS_KEY) begin
         case (unlock_ff)
            wdg_pkg::WDG_LOCKED:
               nxt_unlock = (sfrWdata == `WDG_KEY_UNLOCK_1) ?
                            wdg_pkg::WDG_GOT1 : wdg_pkg::WDG_LOCKED;
            wdg_pkg::WDG_GOT1:
               nxt_unlock = (sfrWdata == `WDG_KEY_UNLOCK_2) ?
                            wdg_pkg::WDG_GOT2 : wdg_pkg::WDG_LOCKED;
            wdg_pkg::WDG_GOT2:
               nxt_unlock = (sfrWdata == `WDG_KEY_UNLOCK_3) ?
                            wdg_pkg::WDG_OPEN : wdg_pkg::WDG_LOCKED;
            wdg_pkg::WDG_OPEN:
               nxt_unlock = (sfrWdata == `WDG_KEY_UNLOCK_1) ?
                            wdg_pkg::WDG_GOT1 : wdg_pkg::WDG_LOCKED;
            default:
               nxt_unlock = wdg_pkg::WDG_LOCKED;
         endcase
      end else if (wrRstCtl || wrIrqCtl) begin
         nxt_unlock = wdg_pkg::WDG_LOCKED;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         unlock_ff <= wdg_pkg::WDG_LOCKED;
      end else if (chipRst_ff) begin
         unlock_ff <= wdg_pkg::WDG_LOCKED;
      end else begin
         unlock_ff <= nxt_unlock;
      end
   end

   assign ctlOpen  = (unlock_ff == wdg_pkg::WDG_OPEN); // R12
   assign wrRstCtl = sfrWr && ctlOpen && (sfrAddr == `WDG_ADDR_RSTCTL);
   assign wrIrqCtl = sfrWr && ctlOpen && (sfrAddr == `WDG_ADDR_IRQCTL);

   // Reset control; a watchdog overflow resets it like any chip reset.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rstEn_ff  <= 1'b0; // R07 R11
         rstDiv_ff <= 4'(`WDG_RSTCTL_RESET); // R04
      end else if (chipRst_ff) begin
         rstEn_ff  <= 1'b0; // R07
         rstDiv_ff <= 4'(`WDG_RSTCTL_RESET);
      end else if (wrRstCtl) begin
         rstEn_ff  <= rstEn_ff | sfrWdata[`WDG_BIT_ENABLE]; // R08
         rstDiv_ff <= sfrWdata[3:0];
      end
   end

   // Interrupt control; overflow sets the flag and wins over a clear.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irqEn_ff  <= 1'b0;
         irqDiv_ff <= 4'(`WDG_IRQCTL_RESET);
         irqOvf_ff <= 1'b0;
      end else if (chipRst_ff) begin
         irqEn_ff  <= 1'b0;
         irqDiv_ff <= 4'(`WDG_IRQCTL_RESET);
         irqOvf_ff <= 1'b0;
      end else begin
         if (wrIrqCtl) begin
            irqEn_ff  <= sfrWdata[`WDG_BIT_ENABLE];
            irqDiv_ff <= sfrWdata[3:0];
         end
         if (irqTk.overflow) begin
            irqOvf_ff <= 1'b1; // R13
         end else if (wrIrqCtl && !sfrWdata[`WDG_BIT_IRQOVF]) begin
            irqOvf_ff <= 1'b0; // R13
         end
      end
   end

   // Reset-cause flag; only power-on reset and software clear it.
   always_ff @(posedge clk or posedge porRst) begin
      if (porRst) begin
         dogCause_ff <= 1'b0;
      end else if (rstTk.overflow) begin
         dogCause_ff <= 1'b1; // R10
      end else if (sfrWr && sfrAddr == `WDG_ADDR_RSTCAUSE
                   && !sfrWdata[`WDG_BIT_DOGCAUSE]) begin
         dogCause_ff <= 1'b0; // R10
      end
   end

   // Chip reset request follows overflow of the running reset timer.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chipRst_ff <= 1'b0;
      end else begin
         chipRst_ff <= rstTk.overflow && rstEn_ff; // R01 R06 R10
      end
   end

   // Interrupt enable in the second enable register and the request flag.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irqEnTwo_ff <= 1'b0;
      end else if (sfrWr && sfrAddr == `WDG_ADDR_IRQEN2) begin
         irqEnTwo_ff <= sfrWdata[`WDG_BIT_IRQEN2];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dogIrq_ff <= 1'b0;
         wake_ff   <= 1'b0;
      end else begin
         dogIrq_ff <= irqOvf_ff && irqEnTwo_ff; // R14 R15 R16
         wake_ff   <= irqTk.overflow && irqEn_ff; // R14
      end
   end

   // Interrupt vector address, held in a register like every output.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irqVec_ff <= `WDG_IRQ_VECTOR;
      end else begin
         irqVec_ff <= `WDG_IRQ_VECTOR; // R15
      end
   end

   // Read path; the key registers read as zero.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= 8'h00;
      end else if (sfrRd) begin
         case (sfrAddr)
            `WDG_ADDR_RSTCTL:
               rdata_ff <= {2'b00, rstEn_ff, 1'b0, rstDiv_ff};
            `WDG_ADDR_IRQCTL:
               rdata_ff <= {2'b00, irqEn_ff, irqOvf_ff, irqDiv_ff};
            `WDG_ADDR_RSTCAUSE:
               rdata_ff <= {4'h0, dogCause_ff, 3'b000};
            `WDG_ADDR_IRQEN2:
               rdata_ff <= {6'h00, irqEnTwo_ff, 1'b0};
            default:
               rdata_ff <= 8'h00;
         endcase
      end
   end

   assign sfrRdata   = rdata_ff;
   assign chipRstReq = chipRst_ff;
   assign irqReq     = dogIrq_ff;
   assign wakeReq    = wake_ff;
   assign irqVector  = irqVec_ff; // R15
endmodule : wdg_watchdog
